//--- bridge_cfg_defines.vh
`ifndef BRIDGE_CFG_DEFINES_VH
`define BRIDGE_CFG_DEFINES_VH
`define OFS_UP_SPLIT 8'h88
`define OFS_DN_SPLIT 8'h8c
`define OFS_PWR_CAP 8'h90
`define OFS_PWR_CSR 8'h94
`define OFS_WIN0_BASE 8'h98
`define OFS_WIN0_SETUP 8'h9c
`define OFS_SLOT_CAP 8'ha0
`define SPLIT_CAP_VAL 16'h0010
`define SPLIT_LIMIT_RST 16'h0010
`define SPLIT_LIMIT_ALL 16'hffff
`define PWR_CAP_ID 8'h01
`define PWR_CAP_NEXT 8'ha8
`define PWR_VERSION 3'h2
`define PWR_AUX_CUR 3'h1
`define PWR_WAKE_SUP 5'h19
`define PSTATE_D0 2'h0
`define PSTATE_D1 2'h1
`define PSTATE_D2 2'h2
`define PSTATE_D3 2'h3
`define CSR_WAKE_EN_BIT 8
`define CSR_WAKE_ST_BIT 15
`define WIN_MASK_RST 19'h7ffff
`define WIN_BASE_RST 20'h00000
`define SLOT_CAP_ID 8'h04
`define SLOT_CAP_NEXT 8'hb0
`define SPLIT_STATUS_DLY_BIT 21
`endif

//--- bridge_split_pm_xlate_cfg.v
// Notes on behaviour
// - upstream split buffer capacity reads 0010h, read-only
// - downstream split buffer capacity reads 0010h, read-only
// - per-direction commitment limit, resets 0010h; ffffh forwards everything
// - split request without room is held; sticky delayed flag set, cleared by up_delay_clr/dn_delay_clr
// - power slot_cap_identifier 01h, next pointer a8h
// - power version reads revision 2.0 code, read-only
// - no wake clock needed, no device-specific init
// - aux current field reads 55 mA code
// - d1/d2 unsupported; wake support from d3cold, d3hot, d0
// - power state d0=00, d3=11, resets d0; d1/d2 writes ignored
// - write moving d3 to d0 pulses internal reset, not bus reset
// - sticky wake enable gates wake output; sticky w1c wake status
// - data select, scale and data register read zero
// - b2/b3 support and bus power control read zero
// - writable translated base 31:12 replaces window-0 address; 11:0 zero
// - size mask selects which upper address bits get replaced
// - setup type reads zero; address type, prefetch are read-only, serial-load only
// - mask bit one makes base bit writable; mask resets all ones
// - window enable stays one; base sized read returns ones in bit 31 and mask-selected bits
// - slot slot_cap_identifier 04h, next pointer b0h
`include "bridge_cfg_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module bridge_split_pm_xlate_cfg #(
  parameter LIMIT_W = 16
) (
  input wire clk,
  input wire rstn,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [7:0] cfg_addr,
  input wire [31:0] cfg_wdata,
  input wire [3:0] cfg_be,
  output reg [31:0] cfg_rdata,
  input wire serial_load_writable,
  input wire [31:0] serial_load_data,
  input wire wake_event_in,
  output wire wake_event_out,
  output reg soft_reset_pulse,
  input wire up_split_req,
  input wire [15:0] up_split_size,
  input wire [15:0] up_split_done,
  output wire up_split_grant,
  input wire dn_split_req,
  input wire [15:0] dn_split_size,
  input wire [15:0] dn_split_done,
  output wire dn_split_grant,
  input wire up_delay_clr,
  input wire dn_delay_clr,
  output reg up_split_delayed,
  output reg dn_split_delayed,
  input wire [31:0] dn_mem_addr,
  output reg [31:0] dn_mem_addr_xlat
);
  reg [LIMIT_W-1:0] up_limit_reg;
  reg [LIMIT_W-1:0] dn_limit_reg;
  reg [LIMIT_W-1:0] up_used_reg;
  reg [LIMIT_W-1:0] dn_used_reg;
  reg [1:0] pstate_reg;
  reg wake_en_reg;
  reg wake_st_reg;
  reg [19:0] win_base_reg;
  reg [18:0] win_mask_reg;
  reg [1:0] win_atype_reg;
  reg win_pref_reg;
  reg [4:0] slot_num_reg;
  reg first_chassis_reg;
  reg [7:0] chassis_reg;
  wire wr_up = cfg_wr && cfg_addr == `OFS_UP_SPLIT;
  wire wr_dn = cfg_wr && cfg_addr == `OFS_DN_SPLIT;
  wire wr_csr = cfg_wr && cfg_addr == `OFS_PWR_CSR;
  wire wr_base = cfg_wr && cfg_addr == `OFS_WIN0_BASE;
  wire wr_slot = cfg_wr && cfg_addr == `OFS_SLOT_CAP;

  function fits;
    input [LIMIT_W-1:0] limit;
    input [LIMIT_W-1:0] used;
    input [15:0] size;
    reg [LIMIT_W:0] sum;
    begin
      sum = {1'b0, used} + {1'b0, size};
      fits = (limit == `SPLIT_LIMIT_ALL) || (sum <= {1'b0, limit});
    end
  endfunction

  function [LIMIT_W-1:0] used_next;
    input [LIMIT_W-1:0] used;
    input grant;
    input [15:0] size;
    input [15:0] done;
    reg [LIMIT_W-1:0] v;
    begin
      v = grant ? used + size : used;
      used_next = (v > done) ? v - done : {LIMIT_W{1'b0}};
    end
  endfunction

  // requests wait until room appears
  assign up_split_grant = up_split_req &&
    fits(up_limit_reg, up_used_reg, up_split_size);
  assign dn_split_grant = dn_split_req &&
    fits(dn_limit_reg, dn_used_reg, dn_split_size);
  assign wake_event_out = wake_en_reg && wake_st_reg;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      up_limit_reg <= `SPLIT_LIMIT_RST;
      dn_limit_reg <= `SPLIT_LIMIT_RST;
      up_used_reg <= {LIMIT_W{1'b0}};
      dn_used_reg <= {LIMIT_W{1'b0}};
      up_split_delayed <= 1'b0;
      dn_split_delayed <= 1'b0;
    end else begin
      if (wr_up && cfg_be[2])
        up_limit_reg[7:0] <= cfg_wdata[23:16];
      if (wr_up && cfg_be[3])
        up_limit_reg[15:8] <= cfg_wdata[31:24];
      if (wr_dn && cfg_be[2])
        dn_limit_reg[7:0] <= cfg_wdata[23:16];
      if (wr_dn && cfg_be[3])
        dn_limit_reg[15:8] <= cfg_wdata[31:24];
      up_used_reg <= used_next(up_used_reg, up_split_grant, up_split_size,
        up_split_done);
      dn_used_reg <= used_next(dn_used_reg, dn_split_grant, dn_split_size,
        dn_split_done);
      // set wins over clear
      if (up_split_req && !up_split_grant)
        up_split_delayed <= 1'b1;
      else if (up_delay_clr)
        up_split_delayed <= 1'b0;
      if (dn_split_req && !dn_split_grant)
        dn_split_delayed <= 1'b1;
      else if (dn_delay_clr)
        dn_split_delayed <= 1'b0;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pstate_reg <= `PSTATE_D0;
      soft_reset_pulse <= 1'b0;
      wake_en_reg <= 1'b0;
      wake_st_reg <= 1'b0;
    end else begin
      soft_reset_pulse <= 1'b0;
      if (wr_csr && cfg_be[0] && (cfg_wdata[1:0] == `PSTATE_D0 ||
          cfg_wdata[1:0] == `PSTATE_D3)) begin
        pstate_reg <= cfg_wdata[1:0];
        if (pstate_reg == `PSTATE_D3 && cfg_wdata[1:0] == `PSTATE_D0)
          soft_reset_pulse <= 1'b1;
      end
      if (wr_csr && cfg_be[1])
        wake_en_reg <= cfg_wdata[`CSR_WAKE_EN_BIT];
      if (wake_event_in)
        wake_st_reg <= 1'b1;
      else if (wr_csr && cfg_be[1] && cfg_wdata[`CSR_WAKE_ST_BIT])
        wake_st_reg <= 1'b0;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      win_base_reg <= `WIN_BASE_RST;
      win_mask_reg <= `WIN_MASK_RST;
      win_atype_reg <= 2'h0;
      win_pref_reg <= 1'b0;
      slot_num_reg <= 5'h00;
      first_chassis_reg <= 1'b0;
      chassis_reg <= 8'h00;
    end else begin
      if (serial_load_writable) begin
        win_atype_reg <= serial_load_data[2:1];
        win_pref_reg <= serial_load_data[3];
        win_mask_reg <= serial_load_data[30:12];
      end
      if (wr_base)
        win_base_reg <= (win_base_reg & ~{1'b1, win_mask_reg}) |
          (cfg_wdata[31:12] & {1'b1, win_mask_reg});
      if (wr_slot && cfg_be[2]) begin
        slot_num_reg <= cfg_wdata[20:16];
        first_chassis_reg <= cfg_wdata[21];
      end
      if (wr_slot && cfg_be[3])
        chassis_reg <= cfg_wdata[31:24];
    end
  end

  // translation of window-0 addresses
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      dn_mem_addr_xlat <= 32'h00000000;
    else
      dn_mem_addr_xlat <= {(win_base_reg & {1'b1, win_mask_reg}) |
        (dn_mem_addr[31:12] & ~{1'b1, win_mask_reg}),
        dn_mem_addr[11:0]};
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      cfg_rdata <= 32'h00000000;
    else if (cfg_rd) begin
      if (cfg_addr == `OFS_UP_SPLIT)
        cfg_rdata <= {up_limit_reg, `SPLIT_CAP_VAL};
      else if (cfg_addr == `OFS_DN_SPLIT)
        cfg_rdata <= {dn_limit_reg, `SPLIT_CAP_VAL};
      else if (cfg_addr == `OFS_PWR_CAP)
        cfg_rdata <= {`PWR_WAKE_SUP, 2'b00, `PWR_AUX_CUR, 1'b0, 1'b0,
          1'b0, `PWR_VERSION, `PWR_CAP_NEXT, `PWR_CAP_ID};
      else if (cfg_addr == `OFS_PWR_CSR)
        cfg_rdata <= {8'h00, 2'b00, 6'h00, wake_st_reg, 6'h00,
          wake_en_reg, 6'h00, pstate_reg};
      else if (cfg_addr == `OFS_WIN0_BASE)
        cfg_rdata <= {win_base_reg, 12'h000};
      else if (cfg_addr == `OFS_WIN0_SETUP)
        cfg_rdata <= {1'b1, win_mask_reg, 8'h00, win_pref_reg,
          win_atype_reg, 1'b0};
      else if (cfg_addr == `OFS_SLOT_CAP)
        cfg_rdata <= {chassis_reg, 2'b00, first_chassis_reg, slot_num_reg,
          `SLOT_CAP_NEXT, `SLOT_CAP_ID};
      else
        cfg_rdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

//--- bridge_cfg_checker.sv
`timescale 1ns/1ns
`default_nettype none
module bridge_cfg_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic soft_reset_pulse,
  input wire logic up_split_req,
  input wire logic up_split_grant,
  input wire logic up_split_delayed,
  input wire logic [31:0] dn_mem_addr,
  input wire logic [31:0] dn_mem_addr_xlat
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_UP_CAP: assert property (cfg_rd && cfg_addr == 8'h88 |=>
    cfg_rdata[15:0] == 16'h0010) else $error("up capacity wrong");
  AST_DN_CAP: assert property (cfg_rd && cfg_addr == 8'h8c |=>
    cfg_rdata[15:0] == 16'h0010) else $error("down capacity wrong");
  AST_PWR_CAP: assert property (cfg_rd && cfg_addr == 8'h90 |=>
    cfg_rdata == 32'hc842a801) else $error("power capability wrong");
  AST_SLOT_CAP: assert property (cfg_rd && cfg_addr == 8'ha0 |=>
    cfg_rdata[15:0] == 16'hb004) else $error("slot capability wrong");
  AST_SETUP: assert property (cfg_rd && cfg_addr == 8'h9c |=>
    cfg_rdata[31] && cfg_rdata[11:4] == 8'h00 && !cfg_rdata[0])
    else $error("setup fields wrong");
  AST_PULSE: assert property (soft_reset_pulse |-> $past(cfg_wr) &&
    $past(cfg_addr) == 8'h94 && $past(cfg_wdata[1:0]) == 2'b00 ##1
    !soft_reset_pulse) else $error("soft reset pulse wrong");
  AST_GRANT: assert property (up_split_grant |-> up_split_req)
    else $error("grant without request");
  AST_DELAY: assert property ($rose(up_split_delayed) |->
    $past(up_split_req && !up_split_grant)) else $error("bad delay flag");
  AST_XLAT: assert property (dn_mem_addr_xlat[11:0] ==
    $past(dn_mem_addr[11:0])) else $error("low address bits changed");
endmodule
bind bridge_split_pm_xlate_cfg bridge_cfg_checker chk_i (.clk, .rstn,
  .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata, .soft_reset_pulse,
  .up_split_req, .up_split_grant, .up_split_delayed, .dn_mem_addr,
  .dn_mem_addr_xlat);
`default_nettype wire

//--- cfg_host.sv
`timescale 1ns/1ns
`default_nettype none
module cfg_host (
  input wire logic clk,
  input wire logic [31:0] cfg_rdata,
  output var logic cfg_wr,
  output var logic cfg_rd,
  output var logic [7:0] cfg_addr,
  output var logic [31:0] cfg_wdata,
  output var logic [3:0] cfg_be
);
  initial {cfg_wr, cfg_rd, cfg_addr, cfg_wdata, cfg_be} = '0;
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(negedge clk);
    {cfg_wr, cfg_addr, cfg_wdata, cfg_be} = {1'b1, a, d, b};
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] q);
    @(negedge clk);
    {cfg_rd, cfg_addr} = {1'b1, a};
    @(negedge clk);
    cfg_rd = 1'b0;
    @(negedge clk);
    q = cfg_rdata;
  endtask
endmodule
`default_nettype wire

//--- test_bridge_split_pm_xlate_cfg.sv
`timescale 1ns/1ns
`default_nettype none
module test_bridge_split_pm_xlate_cfg;
  logic clk, rstn, wake_event_in, up_split_req, dn_split_req, up_delay_clr;
  logic [15:0] up_split_size, dn_split_size;
  logic [31:0] dn_mem_addr, q;
  wire cfg_wr, cfg_rd, wake_event_out, soft_reset_pulse, up_split_grant;
  wire dn_split_grant, up_split_delayed, dn_split_delayed;
  wire [7:0] cfg_addr;
  wire [3:0] cfg_be;
  wire [31:0] cfg_wdata, cfg_rdata, dn_mem_addr_xlat;
  int n_errors, n_checks, n_pulse, i;
  logic [7:0] ra [7] = '{8'h88, 8'h8c, 8'h90, 8'h94, 8'h98, 8'h9c, 8'ha0};
  logic [31:0] rv [7] = '{32'h00100010, 32'h00100010, 32'hc842a801, 0, 0,
    32'hfffff000, 32'h0000b004};
  cfg_host h (.clk(clk), .cfg_rdata(cfg_rdata), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_be(cfg_be));
  bridge_split_pm_xlate_cfg uut (.clk(clk), .rstn(rstn), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_be(cfg_be), .cfg_rdata(cfg_rdata), .serial_load_writable(1'b0),
    .serial_load_data(32'h0), .wake_event_in(wake_event_in),
    .wake_event_out(wake_event_out), .soft_reset_pulse(soft_reset_pulse),
    .up_split_req(up_split_req), .up_split_size(up_split_size),
    .up_split_done(16'h0), .up_split_grant(up_split_grant),
    .dn_split_req(dn_split_req), .dn_split_size(dn_split_size),
    .dn_split_done(16'h0), .dn_split_grant(dn_split_grant),
    .up_delay_clr(up_delay_clr), .dn_delay_clr(1'b0),
    .up_split_delayed(up_split_delayed), .dn_split_delayed(dn_split_delayed),
    .dn_mem_addr(dn_mem_addr), .dn_mem_addr_xlat(dn_mem_addr_xlat));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task pulse_req(input logic [15:0] s, input logic g, input string n);
    @(negedge clk);
    {up_split_req, up_split_size} = {1'b1, s};
    #1 chk(n, up_split_grant, g);
    @(negedge clk);
    up_split_req = 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (soft_reset_pulse === 1'b1) n_pulse++;
  initial begin
    #50000 n_errors++;
    summarize();
  end
  initial begin
    {rstn, wake_event_in, up_split_req, dn_split_req, up_delay_clr} = '0;
    {up_split_size, dn_split_size, dn_mem_addr} = '0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    for (i = 0; i < 7; i++) begin
      h.rd(ra[i], q);
      chk("reset", q, rv[i]);
    end
    h.wr(8'h90, '1, 4'hf);
    h.wr(8'ha0, '1, 4'hf);
    h.rd(8'h90, q);
    chk("ro_cap", q, 32'hc842a801);
    h.rd(8'ha0, q);
    chk("slot", q, 32'hff3fb004);
    $display("test registers done");
    h.wr(8'h94, 32'h1, 4'hf);
    h.rd(8'h94, q);
    chk("pstate_d1", q, 0);
    h.wr(8'h94, 32'h3, 4'hf);
    h.rd(8'h94, q);
    chk("pstate_d3", q, 3);
    h.wr(8'h94, 32'h0, 4'hf);
    @(negedge clk);
    chk("soft_reset", n_pulse, 1);
    wake_event_in = 1'b1;
    @(negedge clk);
    wake_event_in = 1'b0;
    chk("wake_off", wake_event_out, 0);
    h.wr(8'h94, 32'h100, 4'hf);
    chk("wake_on", wake_event_out, 1);
    h.rd(8'h94, q);
    chk("wake_csr", q, 32'h8100);
    h.wr(8'h94, 32'h8100, 4'hf);
    h.rd(8'h94, q);
    chk("wake_clr", q, 32'h100);
    chk("wake_low", wake_event_out, 0);
    $display("test power done");
    h.wr(8'h88, 32'h00040000, 4'hc);
    h.rd(8'h88, q);
    chk("limit", q, 32'h00040010);
    pulse_req(16'h5, 1'b0, "over_limit");
    chk("up_delayed", up_split_delayed, 1);
    up_delay_clr = 1'b1;
    @(negedge clk);
    up_delay_clr = 1'b0;
    chk("up_clear", up_split_delayed, 0);
    pulse_req(16'h4, 1'b1, "at_limit");
    h.wr(8'h88, 32'hffff0000, 4'hc);
    pulse_req(16'h100, 1'b1, "all_ones");
    {dn_split_req, dn_split_size} = {1'b1, 16'h20};
    #1 chk("dn_grant", dn_split_grant, 0);
    @(negedge clk);
    dn_split_req = 1'b0;
    chk("dn_delayed", dn_split_delayed, 1);
    $display("test split done");
    h.wr(8'h98, '1, 4'hf);
    h.rd(8'h98, q);
    chk("base", q, 32'hfffff000);
    dn_mem_addr = 32'h12345abc;
    repeat (2) @(negedge clk);
    chk("xlat", dn_mem_addr_xlat, 32'hfffffabc);
    h.wr(8'h9c, 32'h0, 4'hf);
    h.rd(8'h9c, q);
    chk("setup", q, 32'hfffff000);
    $display("test window done");
    summarize();
  end
endmodule
`default_nettype wire
